// >>> design/opdc_pkg.sv
// Purpose: Constants for the output pair divider channel
// Assumes: Registers are 8 bits wide, one per 32-bit word
// Notes: Byte address is four times the register index
package opdc_pkg;
    // ==========================================
    // Register map
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_DUTY = 10'h196;
    localparam logic [9:0] IDX_CTRL = 10'h197;
    localparam logic [9:0] IDX_ROUTE = 10'h198;
    localparam logic [9:0] IDX_STATUS = 10'h199;
    localparam logic [9:0] IDX_PATH = 10'h1E1;
    localparam logic [7:0] RST_REG = 8'h00;
    // ==========================================
    // Field positions
    localparam int LOW_LSB = 4;
    localparam int CNT_W = 4;
    localparam int BIT_BYPASS = 7;
    localparam int BIT_NOSYNC = 6;
    localparam int BIT_FORCE = 5;
    localparam int BIT_START = 4;
    localparam int BIT_DIRECT = 1;
    localparam int BIT_DUTY_FIX_OFF = 0;
    localparam int BIT_SRC_OSC = 1;
    localparam int BIT_PRE_BYP = 0;
    localparam logic [1:0] PATH_OSC = 2'h2;
    localparam logic [1:0] PATH_EXT = 2'h0;
    // ==========================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [23:0] PAD_ZERO = 24'h000000;
    // ==========================================
    // Divider state
    typedef enum logic [1:0] {ST_PHASE, ST_LOW, ST_HIGH} opdc_state_t;

    // Word index of a byte address
    function automatic logic [9:0] opdc_idx(input logic [ADDR_W-1:0] a);
        opdc_idx = a[ADDR_W-1:2];
    endfunction : opdc_idx
endpackage : opdc_pkg

// >>> design/opdc_axil.sv
// Purpose: AXI4-Lite slave front end for the divider registers
// Assumes: One write and one read outstanding at most
// Notes: Address and data of a write may come in either order
`timescale 1ns/10ps
module opdc_axil
    import opdc_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset, low
    input wire logic [ADDR_W-1:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Byte enables
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write answer
    output logic bvalid, // Write answer valid
    input wire logic bready, // Write answer ready
    input wire logic [ADDR_W-1:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read answer
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    output logic wr_en, // Register write pulse
    output logic [ADDR_W-1:0] wr_addr, // Register write address
    output logic [7:0] wr_data, // Register write data
    output logic wr_lane0, // Low byte enabled
    input wire logic wr_ok, // Write address mapped
    output logic [ADDR_W-1:0] rd_addr, // Register read address
    input wire logic [7:0] rd_data, // Register read data
    input wire logic rd_ok // Read address mapped
);
    logic aw_got;
    logic w_got;
    logic [3:0] strb_q;
    wire aw_hs = awvalid & awready;
    wire w_hs = wvalid & wready;
    wire ar_hs = arvalid & arready;

    // ==========================================
    // Handshakes; no new item while an answer waits
    assign awready = ~aw_got & ~bvalid;
    assign wready = ~w_got & ~bvalid;
    assign arready = ~rvalid;
    assign wr_en = aw_got & w_got & ~bvalid;
    assign wr_lane0 = strb_q[0];
    assign rd_addr = araddr;

    // Write side capture and answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_addr <= '0;
            wr_data <= 8'h00;
            strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got <= 1'b1;
                wr_addr <= awaddr;
            end
            if (w_hs) begin
                w_got <= 1'b1;
                wr_data <= wdata[7:0];
                strb_q <= wstrb;
            end
            if (wr_en) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read side; data captured with the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            rvalid <= 1'b1;
            rdata <= {PAD_ZERO, rd_ok ? rd_data : 8'h00};
            rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : opdc_axil

// >>> design/opdc_core.sv
// Purpose: Low and high period counter with phase offset
// Assumes: One divider input cycle per aclk cycle
// Notes: run_n low holds the counter idle, as powered down
`timescale 1ns/10ps
module opdc_core
    import opdc_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic run_n, // Sync clear, low
    input wire logic [CNT_W-1:0] low_cnt, // Low cycles minus one
    input wire logic [CNT_W-1:0] high_cnt, // High cycles minus one
    input wire logic [CNT_W-1:0] phase_off, // Offset cycles
    input wire logic start_high, // Start level
    input wire logic restart, // Resync pulse
    output logic level, // Divider output
    output opdc_state_t state, // Counting phase
    output logic [CNT_W-1:0] cnt // Cycles in phase
);
    opdc_state_t next_state;
    opdc_state_t first_state;
    logic [CNT_W-1:0] next_cnt;
    logic next_level;
    wire [CNT_W-1:0] limit = (state == ST_LOW) ? low_cnt :
        (state == ST_HIGH) ? high_cnt : phase_off - 4'h1;

    // ==========================================
    // Segment sequencing
    assign first_state = start_high ? ST_HIGH : ST_LOW;
    always_comb begin
        next_state = state;
        next_cnt = cnt + 4'h1;
        next_level = level;
        if (restart) begin
            // Offset zero skips the hold phase entirely
            next_state = (phase_off == 4'h0) ? first_state : ST_PHASE;
            next_cnt = 4'h0;
            next_level = start_high;
        end else if (cnt >= limit) begin
            // A count lowered mid-segment ends it at once instead of wrapping
            next_cnt = 4'h0;
            unique case (state)
                ST_PHASE: next_state = first_state;
                ST_LOW: begin
                    next_state = ST_HIGH;
                    next_level = 1'b1;
                end
                ST_HIGH: begin
                    next_state = ST_LOW;
                    next_level = 1'b0;
                end
                default: next_state = first_state;
            endcase
        end
    end

    // State flops
    always_ff @(posedge aclk) begin
        if (!run_n) begin
            state <= ST_LOW;
            cnt <= 4'h0;
            level <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            level <= next_level;
        end
    end
endmodule : opdc_core

// >>> design/opdc_top.sv
// Purpose: Divider channel for the third output pair
// Assumes: Clock inputs are levels sampled on aclk
// Notes: Prescaler itself lies outside; only its controls leave
// Operation
// - Low segment lasts low field plus one input cycles.
// - High segment lasts high field plus one input cycles; default zero.
// - Bypass powers down divider and passes input clock to output.
// - Sync-ignore clear obeys chip sync; set ignores it.
// - Force bit gives static high or low; needs sync-ignore set.
// - Start-level bit picks starting output level, default low.
// - Four-bit phase offset shifts output phase, resets to zero.
// - Direct-route clear feeds both pair outputs from the divider.
// - Direct-route set with path 10b sends oscillator to both outputs.
// - Direct-route with path 00b sends external clock; 01b no effect.
// - Duty-fix disable clear enables correction; set turns it off.
// - Path bit one picks prescaler source: external or oscillator.
// - Path bit zero bypasses prescaler; not with oscillator source.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module opdc_top
    import opdc_pkg::*;
(
    input wire logic aclk, // 200 MHz clock
    input wire logic aresetn, // Sync reset, low
    input wire logic [ADDR_W-1:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Byte enables
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write answer
    output logic bvalid, // Write answer valid
    input wire logic bready, // Write answer ready
    input wire logic [ADDR_W-1:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read answer
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic sync_req, // Chip sync pulse
    input wire logic dist_clk_in, // Divider input clock
    input wire logic osc_in, // Internal oscillator level
    input wire logic ext_clk_in, // External clock level
    output logic pair_output_a, // First pair output
    output logic pair_output_b, // Second pair output
    output logic duty_fix_enable, // Duty correction on
    output logic prescale_src_osc, // Prescaler from oscillator
    output logic prescale_bypass, // Prescaler bypassed
    output logic divider_powered_down // Divider held off
);
    // ==========================================
    // Register file
    logic [7:0] reg_duty;
    logic [7:0] reg_ctrl;
    logic [7:0] reg_route;
    logic [7:0] reg_path;
    logic wr_en;
    logic wr_lane0;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_ok;
    logic wr_ok;
    opdc_state_t div_state;
    logic [CNT_W-1:0] div_cnt;
    logic div_level;

    opdc_axil u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_lane0(wr_lane0),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Address decode, shared function for both sides
    wire [9:0] wr_idx = opdc_idx(wr_addr);
    wire [9:0] rd_idx = opdc_idx(rd_addr);
    wire wr_duty = wr_en & wr_lane0 & (wr_idx == IDX_DUTY);
    wire wr_ctrl = wr_en & wr_lane0 & (wr_idx == IDX_CTRL);
    wire wr_route = wr_en & wr_lane0 & (wr_idx == IDX_ROUTE);
    wire wr_path = wr_en & wr_lane0 & (wr_idx == IDX_PATH);
    assign wr_ok = (wr_idx == IDX_DUTY) | (wr_idx == IDX_CTRL) |
        (wr_idx == IDX_ROUTE) | (wr_idx == IDX_PATH) |
        (wr_idx == IDX_STATUS);

    // Writable registers; status word ignores writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_duty <= RST_REG;
            reg_ctrl <= RST_REG;
            reg_route <= RST_REG;
            reg_path <= RST_REG;
        end else begin
            if (wr_duty) reg_duty <= wr_data;
            if (wr_ctrl) reg_ctrl <= wr_data;
            if (wr_route) reg_route <= wr_data;
            if (wr_path) reg_path <= wr_data;
        end
    end

    // Field views
    wire [CNT_W-1:0] low_cnt = reg_duty[LOW_LSB+:CNT_W];
    wire [CNT_W-1:0] high_cnt = reg_duty[CNT_W-1:0];
    wire [CNT_W-1:0] phase_off = reg_ctrl[CNT_W-1:0];
    wire bypass = reg_ctrl[BIT_BYPASS];
    wire nosync = reg_ctrl[BIT_NOSYNC];
    wire force_hi = reg_ctrl[BIT_FORCE];
    wire start_high = reg_ctrl[BIT_START];
    wire direct = reg_route[BIT_DIRECT];
    wire [1:0] path = reg_path[1:0];

    // Status word shows live divider state
    wire [7:0] status = {4'h0, divider_powered_down, div_level, div_state};
    assign rd_ok = (rd_idx == IDX_DUTY) | (rd_idx == IDX_CTRL) |
        (rd_idx == IDX_ROUTE) | (rd_idx == IDX_PATH) |
        (rd_idx == IDX_STATUS);
    assign rd_data = (rd_idx == IDX_DUTY) ? reg_duty :
        (rd_idx == IDX_CTRL) ? reg_ctrl :
        (rd_idx == IDX_ROUTE) ? reg_route :
        (rd_idx == IDX_PATH) ? reg_path :
        (rd_idx == IDX_STATUS) ? status : 8'h00;

    // ==========================================
    // Divider control
    // Sync only reaches a divider that obeys it
    wire restart = sync_req & ~nosync;
    // Bypass holds the counter cleared, as powered down
    wire run_n = aresetn & ~bypass;

    opdc_core u_core (
        .aclk(aclk),
        .run_n(run_n),
        .low_cnt(low_cnt),
        .high_cnt(high_cnt),
        .phase_off(phase_off),
        .start_high(start_high),
        .restart(restart),
        .level(div_level),
        .state(div_state),
        .cnt(div_cnt)
    );

    // ==========================================
    // Output routing
    // Direct paths skip the divider; path 01b and 11b leave it in
    wire direct_osc = direct & (path == PATH_OSC);
    wire direct_ext = direct & (path == PATH_EXT);
    // Force only takes hold once sync is ignored; its bit gives the level
    // Limitation: sync ignored with force low leaves the pair static low
    wire forced = nosync;
    wire next_pair = direct_osc ? osc_in :
        direct_ext ? ext_clk_in :
        forced ? force_hi :
        bypass ? dist_clk_in :
        div_level;

    // One next value feeds both flops so the pair never skews
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pair_output_a <= 1'b0;
            pair_output_b <= 1'b0;
        end else begin
            pair_output_a <= next_pair;
            pair_output_b <= next_pair;
        end
    end

    // Side controls to correction and prescaler
    assign duty_fix_enable = ~reg_route[BIT_DUTY_FIX_OFF];
    assign prescale_src_osc = reg_path[BIT_SRC_OSC];
    // Oscillator source forbids the prescaler bypass
    assign prescale_bypass = reg_path[BIT_PRE_BYP] & ~reg_path[BIT_SRC_OSC];
    assign divider_powered_down = bypass;

    // ==========================================
    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Low segment ends on its count
    a_low_to_high: assert property (
        div_state == ST_LOW && div_cnt == low_cnt && run_n && !restart
        |=> div_state == ST_HIGH && div_level && div_cnt == 4'h0)
        else $error("low segment did not end on count");

    // Low count never overruns
    a_low_bound: assert property (
        div_state == ST_LOW && $stable(low_cnt) |-> div_cnt <= low_cnt)
        else $error("low count overran");

    // High count never overruns
    a_high_bound: assert property (
        div_state == ST_HIGH && $stable(high_cnt) |-> div_cnt <= high_cnt)
        else $error("high count overran");

    // High segment ends on its count
    a_high_to_low: assert property (
        div_state == ST_HIGH && div_cnt == high_cnt && run_n && !restart
        |=> div_state == ST_LOW && !div_level)
        else $error("high segment did not end on count");

    // Bypass passes the input clock
    a_bypass_pass: assert property (
        bypass && !direct_osc && !direct_ext && !forced
        |=> pair_output_a == $past(dist_clk_in))
        else $error("bypass did not pass input clock");

    // Bypass holds the counter idle, as powered down
    a_bypass_idle: assert property (
        bypass |=> div_state == ST_LOW && div_cnt == 4'h0 && !div_level)
        else $error("bypassed divider still counting");

    // Ignored sync never starts an offset hold
    a_sync_ignored: assert property (
        sync_req && nosync && run_n && div_state != ST_PHASE && phase_off != 4'h0
        |=> div_state != ST_PHASE)
        else $error("ignored sync disturbed divider");

    // Forced output holds the force bit level
    a_force_high: assert property (
        forced && !direct_osc && !direct_ext
        |=> pair_output_a == $past(force_hi) && pair_output_b == $past(force_hi))
        else $error("forced level wrong");

    // Restart lands on the start level
    a_start_level: assert property (
        restart && run_n |=> div_level == $past(start_high))
        else $error("restart level wrong");

    // Offset of three holds three cycles, then counts
    a_phase_hold: assert property (
        restart && run_n && phase_off == 4'h3
        ##1 (!sync_req && $stable(reg_ctrl)) [*3]
        |-> div_state == ST_PHASE ##1 div_state != ST_PHASE)
        else $error("phase offset hold wrong");

    // Zero offset skips the hold
    a_phase_zero: assert property (
        restart && run_n && phase_off == 4'h0 |=> div_state != ST_PHASE)
        else $error("zero offset entered hold");

    // Pair outputs always agree
    a_pair_equal: assert property (
        pair_output_a == pair_output_b)
        else $error("pair outputs differ");

    // Oscillator routed straight through
    a_direct_osc: assert property (
        direct_osc |=> pair_output_a == $past(osc_in))
        else $error("oscillator not routed");

    // External clock routed straight through
    a_direct_ext: assert property (
        direct_ext |=> pair_output_a == $past(ext_clk_in))
        else $error("external clock not routed");

    // Correction follows its disable bit
    a_duty_fix: assert property (
        wr_route |=> duty_fix_enable == !$past(wr_data[BIT_DUTY_FIX_OFF]))
        else $error("duty fix enable wrong");

    // Prescaler source follows its path bit
    a_presc_src: assert property (
        wr_path |=> prescale_src_osc == $past(wr_data[BIT_SRC_OSC]))
        else $error("prescaler source wrong");

    // Prescaler bypass follows its bit, never with oscillator
    a_presc_rule: assert property (
        prescale_bypass == (reg_path[BIT_PRE_BYP] && !prescale_src_osc))
        else $error("prescaler bypass wrong");

    // Main scenarios
    c_restart: cover property (restart && run_n ##1 div_state == ST_PHASE);
    c_full_period: cover property (
        div_state == ST_LOW ##1 div_state == ST_HIGH ##1 div_state == ST_LOW);
    c_direct_osc: cover property (direct_osc ##1 pair_output_a);
    c_forced: cover property (forced ##1 pair_output_a);
    c_bypass: cover property (bypass && !forced ##1 pair_output_a);
endmodule : opdc_top

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the output pair divider channel
// Assumes: Bus answers within a few cycles; pair output lags one cycle
// Notes: Bus results go through an expectation queue; pins checked direct
`timescale 1ns/10ps
module testbench
    import opdc_pkg::*;
;
    // ==========================================
    // Stimulus and observed signals
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, sync_req = 1'b0, dist_clk_in = 1'b0, osc_in = 1'b0, ext_clk_in = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, pa, pb, dfe, pso, pbp, pdn;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] exp_q[$];
    int num_errors = 0, checks_done = 0;
    int lo, hi, n;
    logic lv;

    opdc_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .sync_req(sync_req), .dist_clk_in(dist_clk_in),
        .osc_in(osc_in), .ext_clk_in(ext_clk_in), .pair_output_a(pa), .pair_output_b(pb),
        .duty_fix_enable(dfe), .prescale_src_osc(pso), .prescale_bypass(pbp), .divider_powered_down(pdn));

    // ==========================================
    // Clock, 5 ns period
    initial begin
        forever #2.5 aclk = ~aclk;
    end

    task chk(input string what, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", what, e, g);
            num_errors++;
        end
    endtask : chk

    // Bus results are taken off the queue at the accepting edge
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready) chk("read", exp_q.pop_front(), {rresp, rdata});
        if (bvalid === 1'b1 && bready) chk("write", exp_q.pop_front(), {bresp, 32'h0});
    end

    // ==========================================
    // Bus master; address and data offered together, no fixed latency
    task wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] r);
        int k;
        exp_q.push_back({r, 32'h0});
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 50);
        if (bvalid !== 1'b1) pin("bvalid", 1'b1, bvalid);
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] r);
        int k;
        exp_q.push_back({r, 24'h0, d});
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 50);
        if (rvalid !== 1'b1) pin("rvalid", 1'b1, rvalid);
        rready <= 1'b0;
    endtask : rd

    task pin(input string what, input logic e, input logic g);
        chk(what, {33'h0, e}, {33'h0, g});
    endtask : pin

    // Length of the next complete run of level lvl on the pair output
    task runlen(input logic lvl, output int len);
        int k;
        k = 0;
        len = 0;
        while (pa === lvl && k < 40) begin @(posedge aclk); #1; k++; end
        while (pa !== lvl && k < 80) begin @(posedge aclk); #1; k++; end
        while (pa === lvl && len < 40) begin pin("pair_b", pa, pb); @(posedge aclk); #1; len++; end
    endtask : runlen

    // Sync pulse seen at edge N; output answers after edge N+1
    task syncrun(input logic [7:0] ctrl, output logic l0, output int len);
        wr(IDX_CTRL, ctrl, RESP_OKAY);
        @(posedge aclk);
        sync_req <= 1'b1;
        @(posedge aclk);
        sync_req <= 1'b0;
        @(posedge aclk);
        #1;
        l0 = pa;
        len = 0;
        while (pa === l0 && len < 40) begin @(posedge aclk); #1; len++; end
    endtask : syncrun

    // Output must copy the chosen source with one cycle of delay
    task follow(input int which);
        logic r, prev;
        prev = 1'b0;
        for (int i = 0; i < 10; i++) begin
            @(posedge aclk);
            r = 1'($urandom);
            if (which == 0) osc_in <= r;
            else if (which == 1) ext_clk_in <= r;
            else dist_clk_in <= r;
            #1;
            if (i > 0) pin("pair_follow", prev, pa);
            prev = r;
        end
    endtask : follow

    task results;
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    // Watchdog; the whole sequence needs far fewer cycles
    initial begin
        #200us;
        num_errors++;
        results();
    end

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(85));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_DUTY, 8'h00, RESP_OKAY);
        rd(IDX_CTRL, 8'h00, RESP_OKAY);
        rd(IDX_ROUTE, 8'h00, RESP_OKAY);
        #1;
        pin("duty_fix", 1'b1, dfe);
        pin("powered_down", 1'b0, pdn);
        wr(10'h000, 8'h5A, RESP_SLVERR);
        rd(10'h000, 8'h00, RESP_SLVERR);
        $display("Test reset and map done");
        // Counts: both boundaries then random values
        for (int i = 0; i < 4; i++) begin
            lo = (i == 0) ? 0 : (i == 1) ? 15 : int'($urandom % 16);
            hi = (i == 0) ? 15 : (i == 1) ? 0 : int'($urandom % 16);
            wr(IDX_DUTY, {lo[3:0], hi[3:0]}, RESP_OKAY);
            rd(IDX_DUTY, {lo[3:0], hi[3:0]}, RESP_OKAY);
            runlen(1'b0, n);
            chk("low_len", 34'(lo + 1), 34'(n));
            runlen(1'b1, n);
            chk("high_len", 34'(hi + 1), 34'(n));
        end
        $display("Test counts done");
        wr(IDX_DUTY, 8'h00, RESP_OKAY);
        syncrun(8'h13, lv, n);
        pin("start_high", 1'b1, lv);
        chk("sync_high_len", 34'd4, 34'(n));
        syncrun(8'h05, lv, n);
        pin("start_low", 1'b0, lv);
        chk("sync_low_len", 34'd6, 34'(n));
        syncrun(8'h53, lv, n);
        pin("forced_low", 1'b0, lv);
        chk("forced_low_len", 34'd40, 34'(n));
        syncrun(8'h10, lv, n);
        pin("start_zero", 1'b1, lv);
        chk("sync_zero_len", 34'd1, 34'(n));
        $display("Test sync done");
        wr(IDX_CTRL, 8'h60, RESP_OKAY);
        repeat (5) @(posedge aclk);
        #1;
        pin("forced_high", 1'b1, pa);
        repeat (7) @(posedge aclk);
        #1;
        pin("forced_hold", 1'b1, pa);
        wr(IDX_CTRL, 8'h80, RESP_OKAY);
        #1;
        pin("powered_down", 1'b1, pdn);
        rd(IDX_STATUS, 8'h09, RESP_OKAY);
        follow(2);
        $display("Test force and bypass done");
        wr(IDX_PATH, 8'h02, RESP_OKAY);
        wr(IDX_ROUTE, 8'h02, RESP_OKAY);
        #1;
        pin("src_osc", 1'b1, pso);
        pin("pre_bypass", 1'b0, pbp);
        follow(0);
        wr(IDX_PATH, 8'h00, RESP_OKAY);
        follow(1);
        wr(IDX_PATH, 8'h01, RESP_OKAY);
        wr(IDX_ROUTE, 8'h03, RESP_OKAY);
        #1;
        pin("pre_bypass", 1'b1, pbp);
        pin("duty_fix", 1'b0, dfe);
        follow(2);
        wr(IDX_PATH, 8'h03, RESP_OKAY);
        #1;
        pin("pre_bypass_osc", 1'b0, pbp);
        wr(IDX_ROUTE, 8'h00, RESP_OKAY);
        wr(IDX_CTRL, 8'h00, RESP_OKAY);
        runlen(1'b1, n);
        chk("divider_back", 34'd1, 34'(n));
        $display("Test routing done");
        results();
    end
endmodule : testbench
